// ==== dv/asf_codec_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Converter acting as link master in I2S; the bit clock stays still until run_in.
module asf_codec_model (
  input  wire logic run_in,    // Start the link.
  output logic      bclk_out,  // Bit clock, 80 ns.
  output logic      fs_out,    // Frame sync.
  output logic      sd0_out,   // Data to serial_in_0.
  output logic      sd1_out    // Data to serial_in_1.
);
  localparam logic [31:0] L0 = 32'hA5C3F17E;  // Left word, line 0.
  localparam logic [31:0] L1 = 32'h3C0FA596;  // Left word, line 1.
  initial begin
    bclk_out = 1'b0;
    fs_out = 1'b1;
    sd0_out = 1'b0;
    sd1_out = 1'b1;
    wait (run_in);
    // Keep the link edges off the system clock edges so no pad change races a sampling edge.
    #2;
    // Lines change after the falling edge so the rising edge sees them settled.
    forever for (int i = 0; i < 64; i++) begin
      fs_out = !(i >= 31 && i <= 62);
      sd0_out = (i >= 32) ? L0[63 - i] : ~L0[31 - i];
      sd1_out = (i >= 32) ? L1[63 - i] : ~L1[31 - i];
      #40 bclk_out = 1'b1;
      #40 bclk_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/asf_formatter_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// Watches the APB answer of the formatter; the serial side is judged by the bench.
module asf_formatter_assertions (
  input wire logic        clk_in,      // Clock.
  input wire logic        rstn_in,     // Reset, active low.
  input wire logic        psel_in,     // Select.
  input wire logic        penable_in,  // Access phase.
  input wire logic        pwrite_in,   // Direction.
  input wire logic [7:0]  paddr_in,    // Address.
  input wire logic [31:0] prdata_out,  // Read data.
  input wire logic        pready_out,  // Ready.
  input wire logic        pslverr_out  // Error.
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  ready_after_setup_a: assert property (psel_in && !penable_in |=> pready_out && penable_in) else $error("no ready");
  ready_single_a: assert property (pready_out |=> !pready_out) else $error("ready too long");
  err_with_ready_a: assert property (pslverr_out |-> pready_out) else $error("stray error");
  err_unmapped_a: assert property (pready_out && paddr_in > asf_pkg::OFF_TX_DATA_2 |-> pslverr_out) else $error("no error");
  err_mapped_a: assert property (pready_out && paddr_in <= asf_pkg::OFF_TX_DATA_2 && paddr_in[1:0] == 2'b00
    |-> !pslverr_out) else $error("false error");
  rdata_quiet_a: assert property (!pready_out || pwrite_in |-> prdata_out == 32'h0) else $error("data leak");
  status_width_a: assert property (pready_out && !pwrite_in && paddr_in == asf_pkg::OFF_AUDIO_PORT_STATUS
    |-> prdata_out[31:7] == 25'h0) else $error("status bits");
  rx_width_a: assert property (pready_out && !pwrite_in && (paddr_in == asf_pkg::OFF_RX_DATA_0
    || paddr_in == asf_pkg::OFF_RX_DATA_1) |-> prdata_out[31:24] == 8'h0) else $error("word width");
endmodule
bind asf_formatter asf_formatter_assertions asf_formatter_assertions_inst (.clk_in(clk_in), .rstn_in(rstn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

// ==== dv/asf_formatter_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module asf_formatter_bench;
  logic        clk_in, rstn_in, psel, penable, pwrite, run, gp5, errq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdq, prdata_out, cap;
  logic        pready_out, pslverr_out, bclk, fs, sd0, sd1;
  logic [11:0] pin_out, pin_oe_out;
  int          n_mismatch = 0, cmp_count = 0;
  asf_codec_model asf_codec_model_inst (.run_in(run), .bclk_out(bclk), .fs_out(fs), .sd0_out(sd0), .sd1_out(sd1));
  asf_formatter asf_formatter_inst (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pin_in({4'h0, sd1, sd0, gp5, 3'b000, fs, bclk}), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // One APB transfer; the request holds until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // Ends when ready is seen; if ready never comes, only the watchdog ends this wait.
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rdq = prdata_out;
    errq = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rdq & m, e)
    `CHK(errq, ee)
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the thousand or so cycles the tests need.
  initial begin
    #600000;
    n_mismatch++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, run, gp5, rstn_in} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(asf_pkg::OFF_RX_CLOCK_CONTROL, 32'hFFFFFFFF, asf_pkg::RST_ZERO, 1'b0);
    apb(1'b1, asf_pkg::OFF_TX_CLOCK_CONTROL, 32'h0000000B);
    rd(asf_pkg::OFF_RX_CLOCK_CONTROL, 32'hFFFFFFFF, 32'h0, 1'b0);
    rd(asf_pkg::OFF_TX_CLOCK_CONTROL, 32'hFFFFFFFF, 32'h0000000B, 1'b0);
    rd(8'h80, 32'hFFFFFFFF, 32'h0, 1'b1);
    $display("registers done");
    // Audio on pins 0,1,6,7; pin 2 output, pin 5 input, pin 8 disconnected.
    apb(1'b1, asf_pkg::OFF_PORT_FUNCTION_CONTROL, 32'h000000E3);
    apb(1'b1, asf_pkg::OFF_PORT_DIRECTION_CONTROL, 32'h000000C7);
    apb(1'b1, asf_pkg::OFF_GPIO_DATA, 32'h00000004);
    gp5 <= 1'b1;
    repeat (6) @(posedge clk_in);
    `CHK({pin_out[2], pin_oe_out[2], pin_oe_out[8], pin_oe_out[5]}, 4'b1100)
    rd(asf_pkg::OFF_GPIO_DATA, 32'h00000020, 32'h00000020, 1'b0);
    $display("pins done");
    apb(1'b1, asf_pkg::OFF_RX_CLOCK_CONTROL, 32'h00000066);
    apb(1'b1, asf_pkg::OFF_RX_SLOT_MASK_LOW, 32'h00000003);
    apb(1'b1, asf_pkg::OFF_RX_CONTROL, 32'h00000055);
    run <= 1'b1;
    // The section counts from enable, so the first stored word precedes any sync; drain it.
    @(negedge fs);
    apb(1'b0, asf_pkg::OFF_RX_DATA_0, 32'h0);
    do begin
      apb(1'b0, asf_pkg::OFF_AUDIO_PORT_STATUS, 32'h0);
    end while (!(rdq[0] && rdq[3]));
    rd(asf_pkg::OFF_RX_DATA_0, 32'hFFFFFFFF, 32'h00A5C3F1, 1'b0);
    rd(asf_pkg::OFF_RX_DATA_1, 32'hFFFFFFFF, 32'h003C0FA5, 1'b0);
    $display("receive done");
    // Transmit on serial_out_0 with the receive clocks; slot 0 only, left justified 24 bits.
    apb(1'b1, asf_pkg::OFF_SHARED_AUDIO_CONTROL, 32'h00000001);
    apb(1'b1, asf_pkg::OFF_TX_CLOCK_CONTROL, 32'h00000066);
    apb(1'b1, asf_pkg::OFF_TX_SLOT_MASK_LOW, 32'h00000001);
    apb(1'b1, asf_pkg::OFF_TX_DATA_0, 32'h00C35A96);
    apb(1'b1, asf_pkg::OFF_PORT_FUNCTION_CONTROL, 32'h000008E3);
    apb(1'b1, asf_pkg::OFF_PORT_DIRECTION_CONTROL, 32'h000008C7);
    apb(1'b1, asf_pkg::OFF_TX_CONTROL, 32'h00000055);
    @(negedge fs);
    @(posedge bclk);
    for (int k = 0; k < 32; k++) begin
      @(posedge bclk);
      cap = {cap[30:0], pin_out[11]};
    end
    `CHK(cap, 32'hC35A9600)
    `CHK(pin_oe_out[11], 1'b1)
    $display("transmit done");
    test_done();
  end
endmodule
`default_nettype wire

// ==== inc/asf_pkg.sv ====
package asf_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] OFF_SHARED_AUDIO_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RX_CLOCK_CONTROL     = 8'h04;
  localparam logic [7:0] OFF_RX_CONTROL           = 8'h08;
  localparam logic [7:0] OFF_RX_SLOT_MASK_LOW     = 8'h0C;
  localparam logic [7:0] OFF_RX_SLOT_MASK_HIGH    = 8'h10;
  localparam logic [7:0] OFF_TX_CLOCK_CONTROL     = 8'h14;
  localparam logic [7:0] OFF_TX_CONTROL           = 8'h18;
  localparam logic [7:0] OFF_TX_SLOT_MASK_LOW     = 8'h1C;
  localparam logic [7:0] OFF_TX_SLOT_MASK_HIGH    = 8'h20;
  localparam logic [7:0] OFF_AUDIO_PORT_STATUS    = 8'h24;
  localparam logic [7:0] OFF_PORT_FUNCTION_CONTROL = 8'h28;
  localparam logic [7:0] OFF_PORT_DIRECTION_CONTROL = 8'h2C;
  localparam logic [7:0] OFF_GPIO_DATA            = 8'h30;
  localparam logic [7:0] OFF_RX_DATA_0            = 8'h34;
  localparam logic [7:0] OFF_RX_DATA_1            = 8'h38;
  localparam logic [7:0] OFF_TX_DATA_0            = 8'h3C;
  localparam logic [7:0] OFF_TX_DATA_1            = 8'h40;
  localparam logic [7:0] OFF_TX_DATA_2            = 8'h44;

  // Clock control fields (one register per section).
  localparam int CC_FALL_EDGE  = 0;  // Sample on falling edge when set.
  localparam int CC_FS_LOW     = 1;  // Frame active on low level when set.
  localparam int CC_FS_EARLY   = 2;  // Frame sync one bit before data.
  localparam int CC_FS_BIT     = 3;  // Bit-length frame sync when set.
  localparam int CC_SLOT_LSB   = 4;  // Three-bit slot/frame-sync length code.
  // Control fields (one register per section).
  localparam int CR_ENABLE     = 0;
  localparam int CR_LSB_FIRST  = 1;
  localparam int CR_WLEN_LSB   = 2;  // Three-bit word length code.
  localparam int CR_RIGHT_JUST = 5;
  localparam int CR_SLOTS_LSB  = 6;  // Five-bit slots per frame minus one.
  // Shared control field.
  localparam int SC_SYNC_CLK   = 0;  // Transmit uses the receive clocks.
  // Status bit positions.
  localparam int ST_RX_FULL0   = 0;
  localparam int ST_RX_FULL1   = 1;
  localparam int ST_RX_OVERRUN = 2;
  localparam int ST_RX_FRAME   = 3;
  localparam int ST_TX_EMPTY   = 4;
  localparam int ST_TX_UNDERRUN = 5;
  localparam int ST_TX_FRAME   = 6;

  // Pin map of the shared port.
  localparam int NPINS         = 12;
  localparam int PIN_RX_BCLK   = 0;
  localparam int PIN_RX_FSYNC  = 1;
  localparam int PIN_TX_BCLK   = 3;
  localparam int PIN_TX_FSYNC  = 4;
  localparam int PIN_SERIAL_IN_0 = 6;
  localparam int PIN_SERIAL_IN_1 = 7;
  localparam int PIN_SERIAL_OUT_2 = 9;
  localparam int PIN_SERIAL_OUT_1 = 10;
  localparam int PIN_SERIAL_OUT_0 = 11;
  localparam logic [11:0] PIN_AUDIO_OUT_MASK = 12'hE00;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// ==== rtl/asf_formatter.sv ====
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module asf_formatter (
  input  wire logic        clk_in,       // System clock, 100 MHz.
  input  wire logic        rstn_in,      // Asynchronous reset, active low.
  input  wire logic        psel_in,      // APB select.
  input  wire logic        penable_in,   // APB access phase.
  input  wire logic        pwrite_in,    // APB write when high.
  input  wire logic [7:0]  paddr_in,     // APB byte address.
  input  wire logic [31:0] pwdata_in,    // APB write data.
  output logic      [31:0] prdata_out,   // APB read data.
  output logic             pready_out,   // APB ready.
  output logic             pslverr_out,  // APB error on unmapped address.
  input  wire logic [11:0] pin_in,       // Pad input levels.
  output logic      [11:0] pin_out,      // Pad output levels.
  output logic      [11:0] pin_oe_out    // Pad output enables, high drives.
);

  // Slot end index from the slot length code: 8, 12, 16, 20, 24 or 32 bits.
  function automatic logic [4:0] slot_last(input logic [2:0] code);
    unique case (code)
      3'h0:    slot_last = 5'h07;
      3'h1:    slot_last = 5'h0B;
      3'h2:    slot_last = 5'h0F;
      3'h3:    slot_last = 5'h13;
      3'h4:    slot_last = 5'h17;
      default: slot_last = 5'h1F;
    endcase
  endfunction

  // Word length from its code; unused codes fall back to 24 bits.
  function automatic logic [5:0] word_len(input logic [2:0] code);
    unique case (code)
      3'h0:    word_len = 6'h08;
      3'h1:    word_len = 6'h0C;
      3'h2:    word_len = 6'h10;
      3'h3:    word_len = 6'h12;
      3'h4:    word_len = 6'h14;
      default: word_len = 6'h18;
    endcase
  endfunction

  // Advance a {slot, bit} position by one bit, wrapping at the frame end.
  function automatic logic [9:0] step_pos(input logic [9:0] p, input logic [4:0] lb, input logic [4:0] ls);
    if (p[4:0] != lb) begin
      step_pos = {p[9:5], p[4:0] + 5'h01};
    end else if (p[9:5] != ls) begin
      step_pos = {p[9:5] + 5'h01, 5'h00};
    end else begin
      step_pos = 10'h000;
    end
  endfunction

  // Position of the bit sampled with a sync transition; early sync lands on the bit before.
  function automatic logic [9:0] sync_pos(input logic half, input logic early, input logic [4:0] lb,
                                          input logic [4:0] ls);
    if (!early) begin
      sync_pos = {4'h0, half, 5'h00};
    end else if (half) begin
      sync_pos = {5'h00, lb};
    end else begin
      sync_pos = {ls, lb};
    end
  endfunction

  // Map a bit of the slot to the word: {valid, last, index}.
  function automatic logic [6:0] word_bit(input logic [4:0] bitp, input logic [4:0] lb,
                                          input logic [5:0] wl, input logic rj, input logic lsb);
    logic [5:0] len;
    logic [5:0] off;
    logic [5:0] k;
    len = {1'b0, lb} + 6'h01;
    off = (rj && (len > wl)) ? len - wl : 6'h00;
    k   = {1'b0, bitp} - off;
    word_bit[6]   = ({1'b0, bitp} >= off) && (k < wl);
    word_bit[5]   = (k == wl - 6'h01);
    word_bit[4:0] = lsb ? k[4:0] : 5'((wl - 6'h01) - k);
    return word_bit;
  endfunction

  // Registers visible to software.
  logic [31:0] shared_reg;     // Clocking common to both sections.
  logic [31:0] rx_clk_reg;     // Receive clock and sync format.
  logic [31:0] rx_ctl_reg;     // Receive word format and slots.
  logic [31:0] rx_mask_reg;    // Receive slot mask, high half above low half.
  logic [31:0] tx_clk_reg;     // Transmit clock and sync format.
  logic [31:0] tx_ctl_reg;     // Transmit word format and slots.
  logic [31:0] tx_mask_reg;    // Transmit slot mask.
  logic [11:0] pfunc_reg;      // Pin control bits.
  logic [11:0] pdir_reg;       // Pin direction bits.
  logic [11:0] gpio_reg;       // GPIO output levels.
  logic [23:0] rx_data_reg [2];  // Received words, right aligned.
  logic [23:0] tx_data_reg [3];  // Words waiting for transmission.
  logic [6:0]  status_reg;     // Status flags.

  // Synchronised pin levels.
  logic [11:0] pin_filt;       // Filtered pad levels.
  logic [11:0] pin_func;       // Pins serving the audio function.

  // Each pad passes three flops; a change is taken once stages two and three agree.
  for (genvar i = 0; i < asf_pkg::NPINS; i++) begin : g_sync
    logic s1_reg;  // First stage, read only by the second.
    logic s2_reg;  // Second stage.
    logic s3_reg;  // Third stage.
    logic f_reg;   // Accepted level.
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        f_reg  <= 1'b0;
      end else begin
        s1_reg <= pin_in[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          f_reg <= s3_reg;
        end
      end
    end
    assign pin_filt[i] = f_reg;
  end

  // Only both bits set hands the pin to the audio logic; others see it as idle low.
  assign pin_func = pdir_reg & pfunc_reg;

  logic [11:0] aud_in;
  assign aud_in = pin_filt & pin_func;

  // Each section has its own clock and sync pins; shared control can tie transmit to receive.
  logic rx_bclk;
  logic rx_fs;
  logic tx_bclk;
  logic tx_fs;
  assign rx_bclk = aud_in[asf_pkg::PIN_RX_BCLK];
  assign rx_fs   = aud_in[asf_pkg::PIN_RX_FSYNC];
  assign tx_bclk = shared_reg[asf_pkg::SC_SYNC_CLK] ? rx_bclk : aud_in[asf_pkg::PIN_TX_BCLK];
  assign tx_fs   = shared_reg[asf_pkg::SC_SYNC_CLK] ? rx_fs : aud_in[asf_pkg::PIN_TX_FSYNC];

  logic [1:0] rx_din;
  assign rx_din = {aud_in[asf_pkg::PIN_SERIAL_IN_1], aud_in[asf_pkg::PIN_SERIAL_IN_0]};

  // Decoded format of each section; nothing is shared between them.
  logic [4:0] rx_lb, rx_ls, tx_lb, tx_ls;
  logic [5:0] rx_wl, tx_wl;
  assign rx_lb = slot_last(rx_clk_reg[asf_pkg::CC_SLOT_LSB +: 3]);
  assign tx_lb = slot_last(tx_clk_reg[asf_pkg::CC_SLOT_LSB +: 3]);
  assign rx_wl = word_len(rx_ctl_reg[asf_pkg::CR_WLEN_LSB +: 3]);
  assign tx_wl = word_len(tx_ctl_reg[asf_pkg::CR_WLEN_LSB +: 3]);
  assign rx_ls = rx_ctl_reg[asf_pkg::CR_SLOTS_LSB +: 5];
  assign tx_ls = tx_ctl_reg[asf_pkg::CR_SLOTS_LSB +: 5];

  // Bit clock edge and frame sync tracking.
  logic rx_bclk_q, tx_bclk_q, rx_act_q, tx_act_q;
  logic rx_samp, tx_samp, rx_act, tx_act;
  logic [9:0] rx_pos_reg, rx_pos_next, tx_pos_reg, tx_pos_next, tx_drv;
  // Chosen sampling edge of each section.
  assign rx_samp = rx_clk_reg[asf_pkg::CC_FALL_EDGE] ? (rx_bclk_q & ~rx_bclk) : (rx_bclk & ~rx_bclk_q);
  assign tx_samp = tx_clk_reg[asf_pkg::CC_FALL_EDGE] ? (tx_bclk_q & ~tx_bclk) : (tx_bclk & ~tx_bclk_q);
  // Active frame level follows the polarity bit; I2S uses low for the first (left) slot.
  assign rx_act = rx_fs ^ rx_clk_reg[asf_pkg::CC_FS_LOW];
  assign tx_act = tx_fs ^ tx_clk_reg[asf_pkg::CC_FS_LOW];

  // Entering the active level starts a frame; with a word-length sync the leaving edge starts slot one.
  always_comb begin
    logic rs;
    logic rh;
    logic ts;
    logic th;
    rs = rx_act & ~rx_act_q;
    rh = ~rx_clk_reg[asf_pkg::CC_FS_BIT] & ~rx_act & rx_act_q;
    ts = tx_act & ~tx_act_q;
    th = ~tx_clk_reg[asf_pkg::CC_FS_BIT] & ~tx_act & tx_act_q;
    if (rs | rh) begin
      rx_pos_next = sync_pos(rh, rx_clk_reg[asf_pkg::CC_FS_EARLY], rx_lb, rx_ls);
    end else begin
      rx_pos_next = step_pos(rx_pos_reg, rx_lb, rx_ls);
    end
    if (ts | th) begin
      tx_pos_next = sync_pos(th, tx_clk_reg[asf_pkg::CC_FS_EARLY], tx_lb, tx_ls);
    end else begin
      tx_pos_next = step_pos(tx_pos_reg, tx_lb, tx_ls);
    end
    tx_drv = step_pos(tx_pos_next, tx_lb, tx_ls);
  end

  // Bit clock history updates every cycle; sync history and positions advance only on the sampling edge of an enabled section.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_bclk_q  <= 1'b0;
      tx_bclk_q  <= 1'b0;
      rx_act_q   <= 1'b0;
      tx_act_q   <= 1'b0;
      rx_pos_reg <= 10'h000;
      tx_pos_reg <= 10'h000;
    end else begin
      rx_bclk_q <= rx_bclk;
      tx_bclk_q <= tx_bclk;
      if (!rx_ctl_reg[asf_pkg::CR_ENABLE]) begin
        rx_pos_reg <= 10'h000;
      end else if (rx_samp) begin
        rx_act_q   <= rx_act;
        rx_pos_reg <= rx_pos_next;
      end
      if (!tx_ctl_reg[asf_pkg::CR_ENABLE]) begin
        tx_pos_reg <= 10'h000;
      end else if (tx_samp) begin
        tx_act_q   <= tx_act;
        tx_pos_reg <= tx_pos_next;
      end
    end
  end

  // Where the sampled and the next driven bit sit in their words.
  logic [6:0] rx_wb, tx_wb;
  assign rx_wb = word_bit(rx_pos_next[4:0], rx_lb, rx_wl, rx_ctl_reg[asf_pkg::CR_RIGHT_JUST],
                          rx_ctl_reg[asf_pkg::CR_LSB_FIRST]);
  assign tx_wb = word_bit(tx_drv[4:0], tx_lb, tx_wl, tx_ctl_reg[asf_pkg::CR_RIGHT_JUST],
                          tx_ctl_reg[asf_pkg::CR_LSB_FIRST]);

  logic rx_store, tx_load, rx_rd0, rx_rd1;
  // A word completes at its last bit; bits past the word length are never stored.
  assign rx_store = rx_ctl_reg[asf_pkg::CR_ENABLE] & rx_samp & rx_wb[6] & rx_wb[5]
                  & rx_mask_reg[rx_pos_next[9:5]];
  assign tx_load  = tx_ctl_reg[asf_pkg::CR_ENABLE] & tx_samp & (tx_drv[4:0] == 5'h00);

  // Receive assembly: each bit lands at its index, so MSB and LSB order differ only in the index.
  logic [23:0] rx_sh_reg [2];
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int c = 0; c < 2; c++) begin
        rx_sh_reg[c]   <= 24'h000000;
        rx_data_reg[c] <= 24'h000000;
      end
    end else if (rx_ctl_reg[asf_pkg::CR_ENABLE] && rx_samp && rx_wb[6]) begin
      for (int c = 0; c < 2; c++) begin
        logic [23:0] w;
        w = (rx_pos_next[4:0] == 5'h00 || !rx_ctl_reg[asf_pkg::CR_RIGHT_JUST] && rx_wb[4:0] == 5'h00
             && rx_ctl_reg[asf_pkg::CR_LSB_FIRST]) ? 24'h000000 : rx_sh_reg[c];
        w[rx_wb[4:0]] = rx_din[c];
        rx_sh_reg[c] <= w;
        if (rx_store) begin
          rx_data_reg[c] <= w;
        end
      end
    end
  end

  // Transmit: a slot's word is latched before its first bit; masked slots send zeros.
  logic [23:0] tx_hold_reg [3];
  logic [2:0]  tx_bit_reg;
  logic        tx_slot_on;
  assign tx_slot_on = tx_mask_reg[tx_drv[9:5]];
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int c = 0; c < 3; c++) begin
        tx_hold_reg[c] <= 24'h000000;
      end
      tx_bit_reg <= 3'h0;
    end else if (!tx_ctl_reg[asf_pkg::CR_ENABLE]) begin
      tx_bit_reg <= 3'h0;
    end else if (tx_samp) begin
      for (int c = 0; c < 3; c++) begin
        logic [23:0] h;
        h = tx_load ? (tx_slot_on ? tx_data_reg[c] : 24'h000000) : tx_hold_reg[c];
        tx_hold_reg[c] <= h;
        // Bits outside the justified word are driven low.
        tx_bit_reg[c] <= tx_wb[6] ? h[tx_wb[4:0]] : 1'b0;
      end
    end
  end

  // Status flags; a hardware set in the same cycle as a software clear wins.
  logic apb_wr, apb_rd;
  assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
  assign apb_rd = psel_in & penable_in & pready_out & ~pwrite_in;
  assign rx_rd0 = apb_rd & (paddr_in == asf_pkg::OFF_RX_DATA_0);
  assign rx_rd1 = apb_rd & (paddr_in == asf_pkg::OFF_RX_DATA_1);
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg <= 7'h00;
    end else begin
      logic wc;
      wc = apb_wr & (paddr_in == asf_pkg::OFF_AUDIO_PORT_STATUS);
      // Full flags clear when software reads the word.
      status_reg[asf_pkg::ST_RX_FULL0] <= rx_store | (status_reg[asf_pkg::ST_RX_FULL0] & ~rx_rd0);
      status_reg[asf_pkg::ST_RX_FULL1] <= rx_store | (status_reg[asf_pkg::ST_RX_FULL1] & ~rx_rd1);
      // Overrun: a new word arrived while the previous serial_in_0 word was unread; write one to clear.
      status_reg[asf_pkg::ST_RX_OVERRUN] <= (rx_store & status_reg[asf_pkg::ST_RX_FULL0])
        | (status_reg[asf_pkg::ST_RX_OVERRUN] & ~(wc & pwdata_in[asf_pkg::ST_RX_OVERRUN]));
      if (rx_store) begin
        status_reg[asf_pkg::ST_RX_FRAME] <= (rx_pos_next[9:5] == 5'h00);
      end
      // Empty sets when a slot takes the data; a write to the first data word clears it.
      status_reg[asf_pkg::ST_TX_EMPTY] <= (tx_load & tx_slot_on)
        | (status_reg[asf_pkg::ST_TX_EMPTY] & ~(apb_wr & (paddr_in == asf_pkg::OFF_TX_DATA_0)));
      status_reg[asf_pkg::ST_TX_UNDERRUN] <= (tx_load & tx_slot_on & status_reg[asf_pkg::ST_TX_EMPTY])
        | (status_reg[asf_pkg::ST_TX_UNDERRUN] & ~(wc & pwdata_in[asf_pkg::ST_TX_UNDERRUN]));
      if (tx_load & tx_slot_on) begin
        status_reg[asf_pkg::ST_TX_FRAME] <= (tx_drv[9:5] == 5'h00);
      end
    end
  end

  // Software writes to the configuration and data registers.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shared_reg  <= asf_pkg::RST_ZERO;
      rx_clk_reg  <= asf_pkg::RST_ZERO;
      rx_ctl_reg  <= asf_pkg::RST_ZERO;
      rx_mask_reg <= asf_pkg::RST_ZERO;
      tx_clk_reg  <= asf_pkg::RST_ZERO;
      tx_ctl_reg  <= asf_pkg::RST_ZERO;
      tx_mask_reg <= asf_pkg::RST_ZERO;
      pfunc_reg   <= 12'h000;
      pdir_reg    <= 12'h000;
      gpio_reg    <= 12'h000;
      for (int c = 0; c < 3; c++) begin
        tx_data_reg[c] <= 24'h000000;
      end
    end else if (apb_wr) begin
      unique case (paddr_in)
        asf_pkg::OFF_SHARED_AUDIO_CONTROL:   shared_reg <= {31'h0, pwdata_in[0]};
        asf_pkg::OFF_RX_CLOCK_CONTROL:       rx_clk_reg <= {25'h0, pwdata_in[6:0]};
        asf_pkg::OFF_RX_CONTROL:             rx_ctl_reg <= {21'h0, pwdata_in[10:0]};
        asf_pkg::OFF_RX_SLOT_MASK_LOW:       rx_mask_reg[15:0] <= pwdata_in[15:0];
        asf_pkg::OFF_RX_SLOT_MASK_HIGH:      rx_mask_reg[31:16] <= pwdata_in[15:0];
        asf_pkg::OFF_TX_CLOCK_CONTROL:       tx_clk_reg <= {25'h0, pwdata_in[6:0]};
        asf_pkg::OFF_TX_CONTROL:             tx_ctl_reg <= {21'h0, pwdata_in[10:0]};
        asf_pkg::OFF_TX_SLOT_MASK_LOW:       tx_mask_reg[15:0] <= pwdata_in[15:0];
        asf_pkg::OFF_TX_SLOT_MASK_HIGH:      tx_mask_reg[31:16] <= pwdata_in[15:0];
        asf_pkg::OFF_PORT_FUNCTION_CONTROL:  pfunc_reg <= pwdata_in[11:0];
        asf_pkg::OFF_PORT_DIRECTION_CONTROL: pdir_reg <= pwdata_in[11:0];
        asf_pkg::OFF_GPIO_DATA:              gpio_reg <= pwdata_in[11:0];
        asf_pkg::OFF_TX_DATA_0:              tx_data_reg[0] <= pwdata_in[23:0];
        asf_pkg::OFF_TX_DATA_1:              tx_data_reg[1] <= pwdata_in[23:0];
        asf_pkg::OFF_TX_DATA_2:              tx_data_reg[2] <= pwdata_in[23:0];
        default: ;
      endcase
    end
  end

  // Read mux; decoding happens in the setup phase so the access phase never waits.
  logic [31:0] rd_mux;
  logic        rd_err;
  always_comb begin
    rd_err = 1'b0;
    unique case (paddr_in)
      asf_pkg::OFF_SHARED_AUDIO_CONTROL:   rd_mux = shared_reg;
      asf_pkg::OFF_RX_CLOCK_CONTROL:       rd_mux = rx_clk_reg;
      asf_pkg::OFF_RX_CONTROL:             rd_mux = rx_ctl_reg;
      asf_pkg::OFF_RX_SLOT_MASK_LOW:       rd_mux = {16'h0, rx_mask_reg[15:0]};
      asf_pkg::OFF_RX_SLOT_MASK_HIGH:      rd_mux = {16'h0, rx_mask_reg[31:16]};
      asf_pkg::OFF_TX_CLOCK_CONTROL:       rd_mux = tx_clk_reg;
      asf_pkg::OFF_TX_CONTROL:             rd_mux = tx_ctl_reg;
      asf_pkg::OFF_TX_SLOT_MASK_LOW:       rd_mux = {16'h0, tx_mask_reg[15:0]};
      asf_pkg::OFF_TX_SLOT_MASK_HIGH:      rd_mux = {16'h0, tx_mask_reg[31:16]};
      asf_pkg::OFF_AUDIO_PORT_STATUS:      rd_mux = {25'h0, status_reg};
      asf_pkg::OFF_PORT_FUNCTION_CONTROL:  rd_mux = {20'h0, pfunc_reg};
      asf_pkg::OFF_PORT_DIRECTION_CONTROL: rd_mux = {20'h0, pdir_reg};
      asf_pkg::OFF_GPIO_DATA:              rd_mux = {20'h0, pin_filt};
      asf_pkg::OFF_RX_DATA_0:              rd_mux = {8'h0, rx_data_reg[0]};
      asf_pkg::OFF_RX_DATA_1:              rd_mux = {8'h0, rx_data_reg[1]};
      asf_pkg::OFF_TX_DATA_0:              rd_mux = {8'h0, tx_data_reg[0]};
      asf_pkg::OFF_TX_DATA_1:              rd_mux = {8'h0, tx_data_reg[1]};
      asf_pkg::OFF_TX_DATA_2:              rd_mux = {8'h0, tx_data_reg[2]};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // APB answer: ready, data and error are registered in the setup cycle.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & rd_err;
      prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  end

  // Pads: audio function pins drive the serial outputs; GPIO outputs drive the data register.
  logic [11:0] aud_out;
  assign aud_out = {tx_bit_reg[0], tx_bit_reg[1], tx_bit_reg[2], 9'h000};
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_out    <= 12'h000;
      pin_oe_out <= 12'h000;
    end else begin
      pin_out    <= (pin_func & aud_out) | (~pin_func & gpio_reg);
      pin_oe_out <= (pin_func & asf_pkg::PIN_AUDIO_OUT_MASK) | (pdir_reg & ~pfunc_reg);
    end
  end

endmodule

`default_nettype wire
